// file: bisync_tx_pkg.sv
// Shared constants, selects and types for the synchronous transmit channel
package bisync_tx_pkg;

    // Register selects on the parallel side
    localparam logic [3:0] SEL_CMD       = 4'h0;
    localparam logic [3:0] SEL_INT_CTRL  = 4'h1;
    localparam logic [3:0] SEL_RX_CTRL   = 4'h3;
    localparam logic [3:0] SEL_MODE      = 4'h4;
    localparam logic [3:0] SEL_TX_CTRL   = 4'h5;
    localparam logic [3:0] SEL_SYNC1     = 4'h6;
    localparam logic [3:0] SEL_SYNC2     = 4'h7;
    localparam logic [3:0] SEL_TX_DATA   = 4'h8;

    // Command register fields
    localparam int         CMD_LSB       = 3;
    localparam int         CMD_MSB       = 5;
    localparam int         CRC_CMD_LSB   = 6;
    localparam int         CRC_CMD_MSB   = 7;
    localparam logic [2:0] CMD_RESET_EXT = 3'h2;
    localparam logic [2:0] CMD_CHAN_RST  = 3'h3;
    localparam logic [2:0] CMD_CLR_TX_IP = 3'h5;
    localparam logic [1:0] CRC_CMD_TXCRC = 2'h2;
    localparam logic [1:0] CRC_CMD_EOM   = 2'h3;

    // Interrupt control register bits
    localparam int INT_EXT_EN  = 0;
    localparam int INT_TX_EN   = 1;
    localparam int INT_SAV     = 2;
    localparam int INT_WR_FUNC = 6;
    localparam int INT_WR_EN   = 7;

    // Receive control: auto enables
    localparam int RX_AUTO_EN  = 5;

    // Mode register: 16-bit sync form
    localparam int MODE_SYNC16 = 4;

    // Transmit control register bits
    localparam int TXC_CRC_EN  = 0;
    localparam int TXC_RTS     = 1;
    localparam int TXC_CRC16   = 2;
    localparam int TXC_TX_EN   = 3;
    localparam int TXC_BREAK   = 4;
    localparam int TXC_LEN_LSB = 5;
    localparam int TXC_LEN_MSB = 6;

    // Character lengths and fill sizes
    localparam logic [4:0] BITS_5  = 5'h05;
    localparam logic [4:0] BITS_6  = 5'h06;
    localparam logic [4:0] BITS_7  = 5'h07;
    localparam logic [4:0] BITS_8  = 5'h08;
    localparam logic [4:0] BITS_16 = 5'h10;
    localparam logic [4:0] BITS_1  = 5'h01;

    // Polynomials and CRC reset value
    localparam logic [15:0] POLY_CRC16 = 16'h8005;
    localparam logic [15:0] POLY_SDLC  = 16'h1021;
    localparam logic [15:0] CRC_INIT   = 16'h0000;

    // Interrupt vector codes
    localparam logic [1:0] VEC_PLAIN = 2'h0;
    localparam logic [1:0] VEC_TX    = 2'h1;
    localparam logic [1:0] VEC_EXT   = 2'h2;

    // Status bundle positions seen by the host
    localparam int ST_BUF_EMPTY = 0;
    localparam int ST_EOM       = 1;
    localparam int ST_CTS       = 2;
    localparam int ST_TX_INT    = 3;
    localparam int ST_EXT_INT   = 4;
    localparam int ST_WAIT      = 5;
    localparam int ST_WIDTH     = 6;

    typedef enum logic [2:0] {TX_MARK, TX_BREAK, TX_DATA, TX_SYNC, TX_CRC} tx_state_t;
    typedef enum logic [1:0] {H_IDLE, H_REQ, H_REL} host_state_t;

    // One serial bit through the CRC register
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in,
                                             input logic [15:0] poly);
        logic fb;
        fb = crc[15] ^ bit_in;
        crc_step = {crc[14:0], 1'b0} ^ (fb ? poly : CRC_INIT);
    endfunction : crc_step

endpackage : bisync_tx_pkg

// file: tx_bus_if.sv
// Parallel-side connection between host loader and transmit channel
`timescale 1ns/10ps
`default_nettype none
interface tx_bus_if;
    logic       wr_req;
    logic [3:0] wr_sel;
    logic [7:0] wr_data;
    logic       wr_ack;
    logic       buf_empty;
    logic       underrun_eom;
    logic       cts_state;
    logic       tx_int;
    logic       ext_int;
    logic       wait_ready;
    logic [1:0] int_vector;

    modport host (output wr_req, output wr_sel, output wr_data, input wr_ack,
                  input buf_empty, input underrun_eom, input cts_state, input tx_int,
                  input ext_int, input wait_ready, input int_vector);
    modport device (input wr_req, input wr_sel, input wr_data, output wr_ack,
                    output buf_empty, output underrun_eom, output cts_state, output tx_int,
                    output ext_int, output wait_ready, output int_vector);
endinterface : tx_bus_if
`default_nettype wire

// file: bisync_tx_host.sv
// Host-side loader: passes register writes across to the transmit channel
`timescale 1ns/10ps
`default_nettype none
module bisync_tx_host
    import bisync_tx_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    // Command port
    input  wire logic       i_cmd_valid,
    input  wire logic [3:0] i_cmd_sel,
    input  wire logic [7:0] i_cmd_data,
    output logic            o_cmd_ready,
    output logic            o_cmd_refused,
    // Channel status
    output logic            o_buf_empty,
    output logic            o_underrun_eom,
    output logic            o_clear_to_send,
    output logic            o_tx_int,
    output logic            o_ext_int,
    output logic            o_wait_ready,
    output logic [1:0]      o_int_vector,
    // Channel
    tx_bus_if.host          bus
);
    host_state_t         state_ff, nxt_state;
    logic                req_ff;
    logic [3:0]          sel_ff;
    logic [7:0]          data_ff;
    logic                mode_seen_ff;
    logic                ready_ff;
    logic                refused_ff;
    logic                ack_s1, ack_s2;
    logic [ST_WIDTH-1:0] st_s1, st_s2;
    logic [1:0]          vec_s1, vec_s2;

    wire needs_mode = (i_cmd_sel == SEL_INT_CTRL) || (i_cmd_sel == SEL_RX_CTRL) ||
                      (i_cmd_sel == SEL_TX_CTRL) || (i_cmd_sel == SEL_SYNC1) || (i_cmd_sel == SEL_SYNC2);
    wire taken      = i_cmd_valid && ready_ff;
    wire refuse     = taken && needs_mode && !mode_seen_ff; // see (R1)
    wire launch     = taken && !refuse;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            H_IDLE:  if (launch) nxt_state = H_REQ;
            H_REQ:   if (ack_s2) nxt_state = H_REL;
            H_REL:   if (!ack_s2) nxt_state = H_IDLE;
            default: nxt_state = H_IDLE;
        endcase
    end

    // Status and acknowledge come from the link domain
    always_ff @(posedge i_clock) begin
        ack_s1 <= bus.wr_ack;
        ack_s2 <= ack_s1;
        st_s1  <= {bus.wait_ready, bus.ext_int, bus.tx_int, bus.cts_state, bus.underrun_eom, bus.buf_empty};
        st_s2  <= st_s1;
        vec_s1 <= bus.int_vector;
        vec_s2 <= vec_s1;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_ff     <= H_IDLE;
            req_ff       <= 1'b0;
            sel_ff       <= SEL_CMD;
            data_ff      <= 8'h00;
            mode_seen_ff <= 1'b0;
            ready_ff     <= 1'b0;
            refused_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            req_ff     <= (nxt_state == H_REQ);
            ready_ff   <= (nxt_state == H_IDLE) && !launch && !st_s2[ST_WAIT]; // see (R11)
            refused_ff <= refuse;
            if (launch) begin
                sel_ff  <= i_cmd_sel;
                data_ff <= i_cmd_data;
            end
            if (launch && i_cmd_sel == SEL_MODE)
                mode_seen_ff <= 1'b1;
        end
    end

    assign bus.wr_req      = req_ff;
    assign bus.wr_sel      = sel_ff;
    assign bus.wr_data     = data_ff;
    assign o_cmd_ready     = ready_ff;
    assign o_cmd_refused   = refused_ff;
    assign o_buf_empty     = st_s2[ST_BUF_EMPTY];
    assign o_underrun_eom  = st_s2[ST_EOM];
    assign o_clear_to_send = st_s2[ST_CTS];
    assign o_tx_int        = st_s2[ST_TX_INT];
    assign o_ext_int       = st_s2[ST_EXT_INT];
    assign o_wait_ready    = st_s2[ST_WAIT];
    assign o_int_vector    = vec_s2;
endmodule : bisync_tx_host
`default_nettype wire

// file: bisync_tx_device.sv
// Synchronous transmit channel clocked by the x1 transmit clock
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (R1) Mode register written before other control registers
// (R2) CRC-16 or SDLC polynomial, shared selection
// (R3) CRC cleared to zeros on reset
// (R4) Reset-transmit-CRC command clears the accumulator
// (R5) Auto enables: transmit only while clear-to-send
// (R6) Line marks after reset and while disabled
// (R7) Break spaces line at once, discards characters
// (R8) Idle enabled transmitter sends sync continuously
// (R9) Transmit interrupt on buffer full-to-empty
// (R10) Write or clear command drops transmit interrupt
// (R11) Wait stalls CPU; ready requests DMA
// (R12) Underrun when shifter empties with no data
// (R13) Latch set after reset; fill syncs skip CRC
// (R14) Cleared latch: send CRC, then sync, set latch
// (R15) External interrupt when latch becomes set
// (R16) Sync-fill interrupt after first sync loaded
// (R17) Buffer-empty clear while CRC sent, then interrupt
// (R18) CRC enable sampled as character is loaded
// (R19) Transparent underrun sends both sync registers
// (R20) Disable finishes character or CRC, then marks
// (R21) Least-significant bit first, right-justified
// (R22) External interrupt on CRC, sync, CTS change
// (R23) Mark is one, space is zero, x1 clock
module bisync_tx_device
    import bisync_tx_pkg::*;
(
    // Link clock and reset
    input  wire logic i_tx_clock,
    input  wire logic i_sys_rst,
    // Serial line
    input  wire logic i_clear_to_send_n,
    output logic      o_tx_data,
    output logic      o_request_to_send_n,
    // Parallel side
    tx_bus_if.device  bus
);
    logic       rst_s1, rst_s2;
    logic       req_s1, req_s2, req_s3;
    logic       cts_s1, cts_s2, cts_s3;
    logic       ack_ff;
    logic [7:0] int_ctrl_ff, rx_ctrl_ff, mode_ff, tx_ctrl_ff, sync1_ff, sync2_ff;
    logic [7:0] buf_ff;
    logic       buf_full_ff, nxt_buf_full;
    tx_state_t  state_ff, nxt_state;
    logic [15:0] shift_ff, nxt_shift;
    logic [4:0] bits_ff, nxt_bits;
    logic       crc_inc_ff, nxt_crc_inc;
    logic [15:0] crc_ff;
    logic       eom_ff, nxt_eom;
    logic       tx_pend_ff, ext_pend_ff;
    logic       empty_evt, ext_evt;
    logic       txd_ff, rts_n_ff;
    logic       st_empty_ff, st_eom_ff, st_cts_ff, tx_int_ff, ext_int_ff, wait_ff;
    logic [1:0] vec_ff;

    function automatic logic [4:0] char_bits(input logic [1:0] code);
        case (code)
            2'h0:    char_bits = BITS_5;
            2'h1:    char_bits = BITS_7;
            2'h2:    char_bits = BITS_6;
            default: char_bits = BITS_8;
        endcase
    endfunction : char_bits

    // Write decode
    wire        wr_stb    = req_s2 && !req_s3;
    wire [2:0]  cmd       = bus.wr_data[CMD_MSB:CMD_LSB];
    wire [1:0]  crc_cmd   = bus.wr_data[CRC_CMD_MSB:CRC_CMD_LSB];
    wire        wr_cmd    = wr_stb && (bus.wr_sel == SEL_CMD);
    wire        wr_buf    = wr_stb && (bus.wr_sel == SEL_TX_DATA);
    wire        chan_rst  = rst_s2 || (wr_cmd && cmd == CMD_CHAN_RST);
    wire        clr_txip  = wr_cmd && cmd == CMD_CLR_TX_IP;
    wire        clr_ext   = wr_cmd && cmd == CMD_RESET_EXT;
    wire        clr_eom   = wr_cmd && crc_cmd == CRC_CMD_EOM;
    wire        clr_crc   = wr_cmd && crc_cmd == CRC_CMD_TXCRC;
    wire        cts       = cts_s2;
    wire        tx_go     = tx_ctrl_ff[TXC_TX_EN] && (!rx_ctrl_ff[RX_AUTO_EN] || cts); // see (R5)
    wire        brk       = tx_ctrl_ff[TXC_BREAK];
    wire        boundary  = (state_ff == TX_MARK) || (state_ff == TX_BREAK) || (bits_ff == BITS_1);
    wire        sync16    = mode_ff[MODE_SYNC16];
    wire [15:0] poly      = tx_ctrl_ff[TXC_CRC16] ? POLY_CRC16 : POLY_SDLC; // see (R2)
    wire [15:0] sync_word = sync16 ? {sync2_ff, sync1_ff} : {8'h00, sync1_ff}; // see (R19)
    wire        cts_chg   = cts_s2 ^ cts_s3;

    always_comb begin
        nxt_state    = state_ff;
        nxt_shift    = {1'b0, shift_ff[15:1]};
        nxt_bits     = (bits_ff == 5'h00) ? bits_ff : bits_ff - BITS_1;
        nxt_crc_inc  = crc_inc_ff;
        nxt_buf_full = buf_full_ff;
        nxt_eom      = clr_eom ? 1'b0 : eom_ff;
        empty_evt    = 1'b0;
        ext_evt      = 1'b0;
        if (brk) begin
            nxt_state    = TX_BREAK; // see (R7)
            nxt_bits     = 5'h00;
            nxt_buf_full = 1'b0;
        end else if (boundary) begin
            if (!tx_go) begin
                nxt_state = TX_MARK; // see (R6) (R20)
                nxt_bits  = 5'h00;
            end else if (buf_full_ff) begin
                nxt_state    = TX_DATA;
                nxt_shift    = {8'h00, buf_ff}; // see (R21)
                nxt_bits     = char_bits(tx_ctrl_ff[TXC_LEN_MSB:TXC_LEN_LSB]);
                nxt_crc_inc  = tx_ctrl_ff[TXC_CRC_EN]; // see (R18)
                nxt_buf_full = 1'b0;
                empty_evt    = 1'b1; // see (R9) (R17)
            end else if (!eom_ff) begin
                nxt_state = TX_CRC; // see (R12) (R14)
                nxt_shift = crc_ff;
                nxt_bits  = BITS_16;
                nxt_eom   = 1'b1;
                ext_evt   = 1'b1; // see (R15) (R22)
            end else begin
                nxt_state   = TX_SYNC; // see (R8) (R12) (R13)
                nxt_shift   = sync_word;
                nxt_bits    = sync16 ? BITS_16 : BITS_8;
                nxt_crc_inc = 1'b0;
                ext_evt     = (state_ff != TX_SYNC); // see (R16) (R22)
                empty_evt   = (state_ff == TX_CRC); // see (R17)
            end
        end
        if (wr_buf && !brk)
            nxt_buf_full = 1'b1;
    end

    // Crossings into the link domain
    always_ff @(posedge i_tx_clock) begin
        rst_s1 <= i_sys_rst;
        rst_s2 <= rst_s1;
        req_s1 <= bus.wr_req;
        req_s2 <= req_s1;
        req_s3 <= req_s2;
        cts_s1 <= !i_clear_to_send_n;
        cts_s2 <= cts_s1;
        cts_s3 <= cts_s2;
    end

    // Control registers
    always_ff @(posedge i_tx_clock) begin
        if (chan_rst) begin
            int_ctrl_ff <= 8'h00;
            rx_ctrl_ff  <= 8'h00;
            mode_ff     <= 8'h00;
            tx_ctrl_ff  <= 8'h00;
            sync1_ff    <= 8'h00;
            sync2_ff    <= 8'h00;
            buf_ff      <= 8'h00;
        end else if (wr_stb) begin
            if (bus.wr_sel == SEL_INT_CTRL) int_ctrl_ff <= bus.wr_data;
            if (bus.wr_sel == SEL_RX_CTRL)  rx_ctrl_ff  <= bus.wr_data;
            if (bus.wr_sel == SEL_MODE)     mode_ff     <= bus.wr_data;
            if (bus.wr_sel == SEL_TX_CTRL)  tx_ctrl_ff  <= bus.wr_data;
            if (bus.wr_sel == SEL_SYNC1)    sync1_ff    <= bus.wr_data;
            if (bus.wr_sel == SEL_SYNC2)    sync2_ff    <= bus.wr_data;
            if (bus.wr_sel == SEL_TX_DATA)  buf_ff      <= bus.wr_data;
        end
    end

    // Transmitter and CRC
    always_ff @(posedge i_tx_clock) begin
        if (chan_rst) begin
            state_ff    <= TX_MARK;
            shift_ff    <= 16'h0000;
            bits_ff     <= 5'h00;
            crc_inc_ff  <= 1'b0;
            buf_full_ff <= 1'b0;
            eom_ff      <= 1'b1; // see (R13)
            crc_ff      <= CRC_INIT; // see (R3)
            txd_ff      <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            shift_ff    <= nxt_shift;
            bits_ff     <= nxt_bits;
            crc_inc_ff  <= nxt_crc_inc;
            buf_full_ff <= nxt_buf_full;
            eom_ff      <= nxt_eom;
            if (clr_crc)
                crc_ff <= CRC_INIT; // see (R4)
            else if (state_ff == TX_DATA && crc_inc_ff)
                crc_ff <= crc_step(crc_ff, shift_ff[0], poly);
            txd_ff <= (nxt_state == TX_BREAK) ? 1'b0 :
                      (nxt_state == TX_MARK)  ? 1'b1 : nxt_shift[0]; // see (R23)
        end
    end

    // Interrupt pendings: a new event wins over a clear in the same cycle
    always_ff @(posedge i_tx_clock) begin
        if (chan_rst) begin
            tx_pend_ff  <= 1'b0;
            ext_pend_ff <= 1'b0;
        end else begin
            tx_pend_ff  <= empty_evt || (tx_pend_ff && !clr_txip && !wr_buf); // see (R10)
            ext_pend_ff <= ext_evt || cts_chg || (ext_pend_ff && !clr_ext); // see (R22)
        end
    end

    // Registered outputs toward the host and the line
    always_ff @(posedge i_tx_clock) begin
        if (chan_rst) begin
            ack_ff      <= 1'b0;
            rts_n_ff    <= 1'b1;
            st_empty_ff <= 1'b1;
            st_eom_ff   <= 1'b1;
            st_cts_ff   <= 1'b0;
            tx_int_ff   <= 1'b0;
            ext_int_ff  <= 1'b0;
            wait_ff     <= 1'b0;
            vec_ff      <= VEC_PLAIN;
        end else begin
            ack_ff      <= req_s2;
            rts_n_ff    <= !tx_ctrl_ff[TXC_RTS];
            st_empty_ff <= !nxt_buf_full && (nxt_state != TX_CRC); // see (R17)
            st_eom_ff   <= nxt_eom;
            st_cts_ff   <= cts;
            tx_int_ff   <= tx_pend_ff && int_ctrl_ff[INT_TX_EN];
            ext_int_ff  <= ext_pend_ff && int_ctrl_ff[INT_EXT_EN];
            wait_ff     <= int_ctrl_ff[INT_WR_EN] &&
                           (int_ctrl_ff[INT_WR_FUNC] ? !nxt_buf_full : nxt_buf_full); // see (R11)
            vec_ff      <= !int_ctrl_ff[INT_SAV] ? VEC_PLAIN :
                           (ext_pend_ff && int_ctrl_ff[INT_EXT_EN]) ? VEC_EXT : VEC_TX; // see (R22)
        end
    end

    assign o_tx_data           = txd_ff;
    assign o_request_to_send_n = rts_n_ff;
    assign bus.wr_ack          = ack_ff;
    assign bus.buf_empty       = st_empty_ff;
    assign bus.underrun_eom    = st_eom_ff;
    assign bus.cts_state       = st_cts_ff;
    assign bus.tx_int          = tx_int_ff;
    assign bus.ext_int         = ext_int_ff;
    assign bus.wait_ready      = wait_ff;
    assign bus.int_vector      = vec_ff;
endmodule : bisync_tx_device
`default_nettype wire

// file: bisync_tx_properties.sv
// Concurrent checks on the parallel handshake and serial line of the transmit channel
`timescale 1ns/10ps
`default_nettype none
module bisync_tx_properties
    import bisync_tx_pkg::*;
(
    // Link clock and reset
    input  wire logic       i_tx_clock,
    input  wire logic       i_sys_rst,
    // Parallel side
    input  wire logic       wr_req,
    input  wire logic [3:0] wr_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_ack,
    input  wire logic       buf_empty,
    input  wire logic       underrun_eom,
    input  wire logic       cts_state,
    input  wire logic       tx_int,
    // Serial line
    input  wire logic       i_clear_to_send_n,
    input  wire logic       o_tx_data
);
    default clocking cb @(posedge i_tx_clock); endclocking
    default disable iff (i_sys_rst);

    sequence s_take(logic [3:0] s);
        $rose(wr_ack) && wr_sel == s;
    endsequence
    sequence s_space;
        !o_tx_data [*4];
    endsequence
    sequence s_mark;
        o_tx_data [*8];
    endsequence

    // The host drops or raises its request within nanoseconds of the acknowledge edge
    property p_ack_rise;   $rose(wr_ack) |-> $past(wr_req); endproperty
    property p_ack_fall;   $fell(wr_ack) |-> !$past(wr_req); endproperty
    property p_req_hold;
        wr_req && !wr_ack |=> wr_ack || (wr_req && $stable(wr_sel) && $stable(wr_data));
    endproperty
    property p_ack_bound;  $rose(wr_req) |-> ##[1:6] wr_ack; endproperty
    property p_break;
        s_take(SEL_TX_CTRL) ##0 wr_data[TXC_BREAK] |-> ##[0:2] s_space;
    endproperty
    property p_disable;
        s_take(SEL_TX_CTRL) ##0 (!wr_data[TXC_TX_EN] && !wr_data[TXC_BREAK]) |-> ##[0:24] s_mark;
    endproperty
    property p_cts;        $fell(i_clear_to_send_n) |-> ##[1:4] cts_state; endproperty
    property p_chan_rst;
        s_take(SEL_CMD) ##0 wr_data[CMD_MSB:CMD_LSB] == CMD_CHAN_RST
            |-> ##[0:3] (underrun_eom && buf_empty && o_tx_data);
    endproperty
    property p_clr_tx;
        s_take(SEL_CMD) ##0 wr_data[CMD_MSB:CMD_LSB] == CMD_CLR_TX_IP |-> ##[0:3] !tx_int;
    endproperty
    property p_tx_int;     $rose(tx_int) |-> buf_empty; endproperty

    a_ack_rise:  assert property (p_ack_rise)  else $error("ack rose without request");
    a_ack_fall:  assert property (p_ack_fall)  else $error("ack fell with request up");
    a_req_hold:  assert property (p_req_hold)  else $error("request changed before ack");
    a_ack_bound: assert property (p_ack_bound) else $error("ack late");
    a_break:     assert property (p_break)     else $error("break not spacing");
    a_disable:   assert property (p_disable)   else $error("line not marking after disable");
    a_cts:       assert property (p_cts)       else $error("cts state not following pin");
    a_chan_rst:  assert property (p_chan_rst)  else $error("channel reset state wrong");
    a_clr_tx:    assert property (p_clr_tx)    else $error("tx interrupt not cleared");
    a_tx_int:    assert property (p_tx_int)    else $error("tx interrupt with buffer full");
endmodule : bisync_tx_properties
`default_nettype wire

// file: tb_top.sv
// Self-checking bench joining host loader and transmit channel
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import bisync_tx_pkg::*;
;
    logic       i_clock;
    logic       tx_clock;
    logic       i_sys_rst;
    logic       i_cmd_valid;
    logic [3:0] i_cmd_sel;
    logic [7:0] i_cmd_data;
    logic       cts_n;
    logic       o_cmd_ready;
    logic       o_cmd_refused;
    logic       o_buf_empty;
    logic       o_underrun_eom;
    logic       o_clear_to_send;
    logic       o_tx_int;
    logic       o_ext_int;
    logic       o_wait_ready;
    logic [1:0] o_int_vector;
    logic       o_tx_data;
    logic       rts_n;
    logic       last_ref;
    int         n_fail;
    int         n_checks;

    tx_bus_if tx_bus_if_i ();

    bisync_tx_host bisync_tx_host_i (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
        .i_cmd_sel(i_cmd_sel), .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
        .o_cmd_refused(o_cmd_refused), .o_buf_empty(o_buf_empty), .o_underrun_eom(o_underrun_eom),
        .o_clear_to_send(o_clear_to_send), .o_tx_int(o_tx_int), .o_ext_int(o_ext_int),
        .o_wait_ready(o_wait_ready), .o_int_vector(o_int_vector), .bus(tx_bus_if_i.host));

    bisync_tx_device bisync_tx_device_i (
        .i_tx_clock(tx_clock), .i_sys_rst(i_sys_rst), .i_clear_to_send_n(cts_n),
        .o_tx_data(o_tx_data), .o_request_to_send_n(rts_n), .bus(tx_bus_if_i.device));

    bisync_tx_properties bisync_tx_properties_i (
        .i_tx_clock(tx_clock), .i_sys_rst(i_sys_rst), .wr_req(tx_bus_if_i.wr_req),
        .wr_sel(tx_bus_if_i.wr_sel), .wr_data(tx_bus_if_i.wr_data), .wr_ack(tx_bus_if_i.wr_ack),
        .buf_empty(tx_bus_if_i.buf_empty), .underrun_eom(tx_bus_if_i.underrun_eom),
        .cts_state(tx_bus_if_i.cts_state), .tx_int(tx_bus_if_i.tx_int),
        .i_clear_to_send_n(cts_n), .o_tx_data(o_tx_data));

    initial i_clock = 1'b0;
    always #2 i_clock = ~i_clock;
    // Link clock offset so its edges never line up with the system clock
    initial begin
        tx_clock = 1'b0;
        #37;
        forever #80 tx_clock = ~tx_clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Returns at the first edge at which the command port was ready
    task automatic settle();
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_cmd_ready !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            n_fail++;
            print_verdict();
        end
    endtask : settle

    task automatic wr(input logic [3:0] s, input logic [7:0] d);
        @(posedge i_clock);
        i_cmd_valid <= 1'b1;
        i_cmd_sel   <= s;
        i_cmd_data  <= d;
        settle();
        i_cmd_valid <= 1'b0;
        @(posedge i_clock);
        last_ref = o_cmd_refused;
    endtask : wr

    // Searches the line for a w-bit pattern, first bit sent in the low position
    task automatic hunt(input int w, input logic [31:0] exp, input int lim);
        logic [31:0] sr;
        logic        hit;
        int          k;
        sr  = '0;
        hit = 1'b0;
        for (k = 0; k < lim && !hit; k++) begin
            @(negedge tx_clock);
            sr = {o_tx_data, sr[31:1]};
            if (k >= w - 1 && (sr >> (32 - w)) === exp)
                hit = 1'b1;
        end
        chk(hit, 1'b1);
    endtask : hunt

    task automatic hold_lvl(input logic v, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(negedge tx_clock);
            if (o_tx_data !== v)
                ok = 1'b0;
        end
        chk(ok, 1'b1);
    endtask : hold_lvl

    function automatic logic [15:0] crc_ref(input logic [7:0] d);
        logic [15:0] c;
        int          k;
        c = 16'h0000;
        for (k = 0; k < 8; k++) begin
            if (c[15] ^ d[k])
                c = {c[14:0], 1'b0} ^ POLY_CRC16;
            else
                c = {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc_ref

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial begin
        #300000;
        n_fail++;
        print_verdict();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        i_sys_rst = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd_sel = 4'h0;
        i_cmd_data = 8'h00;
        cts_n = 1'b1;
        // Reset spans four link cycles so the channel sees it too
        repeat (4) @(posedge tx_clock);
        @(posedge i_clock);
        i_sys_rst <= 1'b0;
        repeat (8) @(posedge tx_clock);
        chk(o_buf_empty, 1'b1);
        chk(o_underrun_eom, 1'b1);
        chk(o_tx_int, 1'b0);
        chk(o_wait_ready, 1'b0);
        chk(rts_n, 1'b1);
        hold_lvl(1'b1, 8);
        $display("test reset done");
        wr(SEL_TX_CTRL, 8'h68);
        chk(last_ref, 1'b1);
        wr(SEL_MODE, 8'h00);
        chk(last_ref, 1'b0);
        $display("test order done");
        wr(SEL_SYNC1, 8'h0b);
        wr(SEL_INT_CTRL, 8'h03);
        wr(SEL_RX_CTRL, 8'h20);
        wr(SEL_TX_CTRL, 8'h68);
        hold_lvl(1'b1, 16);
        chk(o_clear_to_send, 1'b0);
        @(posedge i_clock);
        cts_n <= 1'b0;
        hunt(8, 32'h0b, 40);
        chk(o_clear_to_send, 1'b1);
        chk(o_ext_int, 1'b1);
        chk(o_buf_empty, 1'b1);
        chk(o_underrun_eom, 1'b1);
        chk(o_int_vector, VEC_PLAIN);
        wr(SEL_CMD, 8'h10);
        settle();
        chk(o_ext_int, 1'b0);
        $display("test sync8 done");
        wr(SEL_SYNC2, 8'h35);
        wr(SEL_MODE, 8'h10);
        hunt(16, 32'h350b, 80);
        $display("test sync16 done");
        wr(SEL_CMD, 8'h80);
        wr(SEL_TX_CTRL, 8'h6d);
        wr(SEL_TX_DATA, 8'ha5);
        hunt(8, 32'ha5, 80);
        chk(o_tx_int, 1'b1);
        wr(SEL_CMD, 8'h28);
        settle();
        chk(o_tx_int, 1'b0);
        wr(SEL_CMD, 8'hc0);
        hunt(16, {16'h0000, crc_ref(8'ha5)}, 160);
        repeat (4) @(posedge tx_clock);
        chk(o_underrun_eom, 1'b1);
        $display("test crc done");
        wr(SEL_TX_CTRL, 8'h78);
        settle();
        hold_lvl(1'b0, 16);
        wr(SEL_TX_CTRL, 8'h60);
        repeat (20) @(posedge tx_clock);
        hold_lvl(1'b1, 16);
        $display("test break done");
        wr(SEL_TX_CTRL, 8'h68);
        wr(SEL_CMD, 8'h18);
        settle();
        repeat (4) @(posedge tx_clock);
        chk(o_underrun_eom, 1'b1);
        chk(o_buf_empty, 1'b1);
        hold_lvl(1'b1, 8);
        $display("test chanreset done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
